// File: hdl/clc_pkg.sv
// Package of register map, field layout and reset values for the logic cell input select
package clc_pkg;
  localparam int unsigned CLC_NUM_MUX = 4;
  localparam int unsigned CLC_SEL_W = 3;
  localparam int unsigned CLC_POOL_MAX = 32;
  localparam logic [3:0] CLC_OFS_SEL = 4'h0;
  localparam logic [3:0] CLC_OFS_GATE = 4'h4;
  localparam logic [3:0] CLC_OFS_CTRL = 4'h8;
  localparam logic [3:0] CLC_OFS_STAT = 4'hc;
  localparam int unsigned CLC_SEL_POS1 = 0;
  localparam int unsigned CLC_SEL_POS2 = 4;
  localparam int unsigned CLC_SEL_POS3 = 8;
  localparam int unsigned CLC_SEL_POS4 = 12;
  localparam logic [15:0] CLC_SEL_MASK = 16'h7777;
  localparam logic [15:0] CLC_SEL_RST = 16'h0000;
  localparam logic [15:0] CLC_GATE_RST = 16'h0000;
  localparam logic [2:0] CLC_CTRL_RST = 3'h0;
  typedef enum logic [1:0] {
    CLC_FN_AND = 2'b00,
    CLC_FN_OR = 2'b01,
    CLC_FN_XOR = 2'b10,
    CLC_FN_AO = 2'b11
  } clc_fn_t;
endpackage : clc_pkg

// File: hdl/clc_src_mux.sv
// One data-source multiplexer picking a signal from its slice of the pool
module clc_src_mux
  import clc_pkg::*;
#(
  parameter int unsigned SEL_W = CLC_SEL_W
) (
  // Candidates and choice
  input wire logic [(1 << SEL_W)-1:0] cand,
  input wire logic [SEL_W-1:0] sel,
  // Picked signal
  output logic picked
);
  always_comb begin
    picked = cand[sel];
  end
endmodule : clc_src_mux

// File: hdl/clc_logic_cell.sv
// Configurable logic cell: source muxes, input gates, logic function, Avalon-MM registers
// What this block does
// - Four input gates feed the selected function only
// - Candidate pool holds at most 32 signals
// - Four independent source muxes, own select each
// - Software picks which of two sources (its own and the next) drive each gate
// - Result drives peripherals and pins
// - Evaluates continuously without software action
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
module clc_logic_cell
  import clc_pkg::*;
#(
  parameter int unsigned POOL = CLC_POOL_MAX
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Signal pool
  input wire logic [POOL-1:0] pool_in,
  // Cell result
  output logic cell_out,
  output logic cell_pin_out,
  output logic cell_pin_oe
);
  logic [15:0] sel_q, sel_d;
  logic [15:0] gate_q, gate_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic out_q, out_d;
  logic [3:0] ds;
  logic [3:0] gate;
  logic func;
  clc_fn_t fn;

  // Merge a byte-enabled write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : merge16

  // Each mux sees eight pool signals; the four slices together cover 32
  genvar m;
  generate
    for (m = 0; m < CLC_NUM_MUX; m++) begin : g_mux
      logic [7:0] cand;
      always_comb begin
        for (int k = 0; k < 8; k++) begin
          cand[k] = ((m * 8 + k) < POOL) ? pool_in[(m * 8 + k) % POOL] : 1'b0;
        end
      end
      clc_src_mux #(.SEL_W(CLC_SEL_W)) u_mux (
        .cand(cand),
        .sel(sel_q[m*4 +: 3]),
        .picked(ds[m])
      );
    end
  endgenerate

  // Gate g takes true/negated enables for sources g and (g+1)%4 from gate_q[g*4 +: 4] pairs
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      gate[g] = 1'b0;
      for (int s = 0; s < 2; s++) begin
        gate[g] = gate[g] | (gate_q[g*4 + s*2] & ds[(g + s) % 4])
                  | (gate_q[g*4 + s*2 + 1] & ~ds[(g + s) % 4]);
      end
    end
  end

  // Only the four gates reach the function
  always_comb begin
    fn = clc_fn_t'(ctrl_q[1:0]);
    case (fn)
      CLC_FN_AND: func = &gate;
      CLC_FN_OR: func = |gate;
      CLC_FN_XOR: func = ^gate;
      CLC_FN_AO: func = (gate[0] & gate[1]) | (gate[2] & gate[3]);
      default: func = 1'b0;
    endcase
  end

  // Bus and output next state
  always_comb begin
    sel_d = sel_q;
    gate_d = gate_q;
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    out_d = func;
    if ((read || write) && !ack_q) begin
      ack_d = 1'b1;
      if (write) begin
        case (address)
          CLC_OFS_SEL: sel_d = merge16(sel_q, writedata, byteenable) & CLC_SEL_MASK;
          CLC_OFS_GATE: gate_d = merge16(gate_q, writedata, byteenable);
          CLC_OFS_CTRL: begin
            if (byteenable[0]) begin
              ctrl_d = writedata[2:0];
            end
          end
          default: ctrl_d = ctrl_q;
        endcase
      end else begin
        case (address)
          CLC_OFS_SEL: rdata_d = {16'h0000, sel_q & CLC_SEL_MASK};
          CLC_OFS_GATE: rdata_d = {16'h0000, gate_q};
          CLC_OFS_CTRL: rdata_d = {29'h0000000, ctrl_q};
          CLC_OFS_STAT: rdata_d = {27'h0000000, gate, out_q};
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= CLC_SEL_RST;
      gate_q <= CLC_GATE_RST;
      ctrl_q <= CLC_CTRL_RST;
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      gate_q <= gate_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      out_q <= out_d;
    end
  end

  // One wait cycle lets read data come from a flop
  assign waitrequest = (read || write) && !ack_q;
  assign readdata = rdata_q;
  assign cell_out = out_q ^ ctrl_q[2];
  assign cell_pin_out = out_q ^ ctrl_q[2];
  assign cell_pin_oe = 1'b1;

  // Assertions
  sel_gaps_a: assert property (@(posedge clk) disable iff (!resetn)
    (sel_q & ~CLC_SEL_MASK) == 16'h0000) else $error("select gap bits set");
  sel_write_a: assert property (@(posedge clk) disable iff (!resetn)
    write && !waitrequest && address == CLC_OFS_SEL && byteenable[1:0] == 2'b11
    |=> sel_q == ($past(writedata[15:0]) & CLC_SEL_MASK)) else $error("select write lost");
  mux_pick_a: assert property (@(posedge clk) disable iff (!resetn)
    ds[0] == pool_in[sel_q[2:0]]) else $error("mux one wrong");
  mux_four_a: assert property (@(posedge clk) disable iff (!resetn)
    ds[3] == pool_in[24 + sel_q[14:12]]) else $error("mux four wrong");
  out_follow_a: assert property (@(posedge clk) disable iff (!resetn)
    out_q == $past(func)) else $error("output not tracking");
  gate_only_a: assert property (@(posedge clk) disable iff (!resetn)
    gate_q == 16'h0000 && fn == CLC_FN_OR |-> !func) else $error("function saw non-gate input");
  gate_true_a: assert property (@(posedge clk) disable iff (!resetn)
    gate_q[0] |-> (ds[0] -> gate[0])) else $error("gate enable ignored");
  pin_match_a: assert property (@(posedge clk) disable iff (!resetn)
    cell_pin_out == cell_out && cell_pin_oe) else $error("pin differs");
  bus_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    (read || write) && !ack_q |-> waitrequest ##1 !waitrequest) else $error("bus stalls");
  wait_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !read && !write |-> !waitrequest) else $error("wait without request");

  // Middle muxes, so every slice of the pool is guarded
  mux_two_a: assert property (@(posedge clk) disable iff (!resetn)
    ds[1] == pool_in[8 + sel_q[6:4]]) else $error("mux two wrong");
  mux_three_a: assert property (@(posedge clk) disable iff (!resetn)
    ds[2] == pool_in[16 + sel_q[10:8]]) else $error("mux three wrong");

  // Gate decode and function choice
  gate_neg_a: assert property (@(posedge clk) disable iff (!resetn)
    gate_q[1] && !ds[0] |-> gate[0]) else $error("negated enable ignored");
  gate_off_a: assert property (@(posedge clk) disable iff (!resetn)
    gate_q[3:0] == 4'h0 |-> !gate[0]) else $error("disabled gate active");
  fn_and_a: assert property (@(posedge clk) disable iff (!resetn)
    fn == CLC_FN_AND |-> func == &gate) else $error("and function wrong");
  fn_xor_a: assert property (@(posedge clk) disable iff (!resetn)
    fn == CLC_FN_XOR |-> func == ^gate) else $error("xor function wrong");

  // Register side: writes land once, reads show what is held
  sel_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !(write && address == CLC_OFS_SEL) |=> $stable(sel_q)) else $error("select changed");
  ctrl_write_a: assert property (@(posedge clk) disable iff (!resetn)
    write && !ack_q && address == CLC_OFS_CTRL && byteenable[0]
    |=> ctrl_q == $past(writedata[2:0])) else $error("control write lost");
  sel_read_a: assert property (@(posedge clk) disable iff (!resetn)
    read && !waitrequest && address == CLC_OFS_SEL
    |-> readdata == {16'h0000, sel_q}) else $error("select read wrong");
  stat_read_a: assert property (@(posedge clk) disable iff (!resetn)
    read && !waitrequest && address == CLC_OFS_STAT
    |-> readdata[31:5] == 27'h0000000) else $error("status upper bits set");
  rdata_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !read |=> $stable(readdata)) else $error("read data moved");

  // Covers for the main scenarios
  sel_rd_c: cover property (@(posedge clk) disable iff (!resetn)
    read && !waitrequest && address == CLC_OFS_SEL);
  out_rise_c: cover property (@(posedge clk) disable iff (!resetn) $rose(out_q));
  xor_fn_c: cover property (@(posedge clk) disable iff (!resetn) fn == CLC_FN_XOR && func);
  inv_out_c: cover property (@(posedge clk) disable iff (!resetn)
    ctrl_q[2] && cell_out);
  sel_wr_c: cover property (@(posedge clk) disable iff (!resetn)
    write && !waitrequest && address == CLC_OFS_SEL);
endmodule : clc_logic_cell

// File: dv/clc_pool_model.sv
// Model of the on-chip signal pool feeding the cell
module clc_pool_model (
  // Clock
  input wire logic clk,
  // Which source is high
  input wire logic [4:0] hot_idx,
  input wire logic hot_en,
  // Pool to the cell
  output logic [31:0] pool
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered, so pool edges never race the cell clock
  always_ff @(posedge clk) begin
    pool <= hot_en ? (32'h1 << hot_idx) : 32'h0;
  end
endmodule : clc_pool_model

// File: dv/tb.sv
// Testbench of the logic cell input select
module tb;
  import clc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0, hot_en = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, rd, pool;
  logic waitrequest, cell_out, cell_pin_out, cell_pin_oe;
  logic [4:0] hot_idx = 5'h0;
  int errors = 0, check_count = 0;
  initial forever #2 clk = ~clk;
  clc_pool_model pm_u (.clk(clk), .hot_idx(hot_idx), .hot_en(hot_en), .pool(pool));
  clc_logic_cell dut_u (.clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'h3), .readdata(readdata),
    .waitrequest(waitrequest), .pool_in(pool), .cell_out(cell_out),
    .cell_pin_out(cell_pin_out), .cell_pin_oe(cell_pin_oe));
  task stop_test;
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request held until waitrequest is seen low, then released after that edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i >= 50) begin
      errors++;
      stop_test();
    end
  endtask : bus
  // Two register stages sit between the bench and the cell output
  task pool_set(input logic [4:0] idx);
    @(posedge clk);
    hot_idx <= idx;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : pool_set
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, CLC_OFS_SEL, 32'h0);
    chk("sel reset", 32'h0, rd);
    chk("pin oe", 32'h1, {31'h0, cell_pin_oe});
    bus(1'b1, CLC_OFS_SEL, 32'hffff);
    bus(1'b0, CLC_OFS_SEL, 32'h0);
    chk("sel gaps", 32'h7777, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, CLC_OFS_GATE, 32'h1111);
    bus(1'b1, CLC_OFS_CTRL, 32'h1);
    bus(1'b0, CLC_OFS_GATE, 32'h0);
    chk("gate rd", 32'h1111, rd);
    bus(1'b0, CLC_OFS_CTRL, 32'h0);
    chk("ctrl rd", 32'h1, rd);
    hot_en <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 8; k++) begin
        bus(1'b1, CLC_OFS_SEL, 32'(k) << (4 * m));
        pool_set(5'(8 * m + k));
        chk("route hit", 32'h1, {31'h0, cell_out});
        chk("pin hit", 32'h1, {31'h0, cell_pin_out});
        pool_set(5'(8 * m + (k + 1) % 8));
        chk("route miss", 32'h0, {31'h0, cell_out});
      end
    end
    bus(1'b1, CLC_OFS_CTRL, 32'h5);
    pool_set(hot_idx);
    chk("invert", 32'h1, {31'h0, cell_out});
    bus(1'b0, CLC_OFS_STAT, 32'h0);
    chk("status", 32'h0, rd);
    stop_test();
  end
endmodule : tb
